//--- dv/nvsr_dev_model.sv
// Behavioural model of the nonvolatile byte memory that answers the host controller.
`timescale 1ns/1ns
module nvsr_dev_model
   import nvsr_pkg::*;
#(
   parameter int SAVE_NS = 400,
   parameter int RESTORE_NS = 400,
   parameter int PUP_NS = 300
)
(
   input wire logic core_clk,
   input wire logic [ADDR_W-1:0] byte_address,
   input wire logic chip_sel_n,
   input wire logic write_n,
   input wire logic out_en_n,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_dev,
   output logic dq_dev_oe_n,
   output logic busy_n
);
   logic [DATA_W-1:0] mem [0:32767];
   logic [DATA_W-1:0] shadow [0:32767];
   logic [DATA_W-1:0] last_r, wd;
   logic [ADDR_W-1:0] wa;
   logic [13:0] seq_tab [0:4];
   logic nv_busy, wr_act, drive;
   int step, save_count, restore_count, viol_count;
   time wr_t0;
   assign seq_tab = '{SEQ_ADDR0, SEQ_ADDR1, SEQ_ADDR2, SEQ_ADDR3, SEQ_ADDR4};
   assign drive = !chip_sel_n && !out_en_n && write_n && !nv_busy;
   assign dq_dev_oe_n = !drive;
   assign dq_dev = drive ? mem[byte_address] : ~last_r;
   always @(posedge core_clk) begin
      last_r <= drive ? mem[byte_address] : ~last_r;
   end
   task automatic restore_all(input int dur);
      nv_busy = 1'b1;
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 8'h00;
      end
      #(dur);
      for (int i = 0; i < 32768; i++) begin
         mem[i] = shadow[i];
      end
      restore_count++;
      nv_busy = 1'b0;
   endtask : restore_all
   task automatic save_all();
      nv_busy = 1'b1;
      busy_n = 1'b0;
      for (int i = 0; i < 32768; i++) begin
         shadow[i] = 8'hff;
      end
      #(SAVE_NS);
      for (int i = 0; i < 32768; i++) begin
         shadow[i] = mem[i];
      end
      save_count++;
      busy_n = 1'b1;
      nv_busy = 1'b0;
   endtask : save_all
   initial begin
      last_r = 8'h00;
      step = 0;
      save_count = 0;
      restore_count = 0;
      viol_count = 0;
      busy_n = 1'b1;
      wr_act = 1'b0;
      wr_t0 = 0;
      for (int i = 0; i < 32768; i++) begin
         shadow[i] = i[7:0] ^ 8'h3c;
      end
      restore_all(PUP_NS);
   end
   always @(negedge chip_sel_n) begin
      #1;
      if (nv_busy) begin
         viol_count++;
      end else if (!write_n) begin
         step = 0;
      end else if (step == 5 && byte_address[13:0] == SEQ_SAVE) begin
         step = 0;
         fork
            save_all();
         join_none
      end else if (step == 5 && byte_address[13:0] == SEQ_RESTORE) begin
         step = 0;
         fork
            restore_all(RESTORE_NS);
         join_none
      end else if (step < 5 && byte_address[13:0] == seq_tab[step]) begin
         step++;
      end else begin
         step = (byte_address[13:0] == SEQ_ADDR0) ? 1 : 0;
      end
   end
   always @(negedge write_n) begin
      if (!chip_sel_n) begin
         step = 0;
      end
   end
   always @(chip_sel_n or write_n or byte_address or dq_in) begin
      if (wr_act && (chip_sel_n || write_n)) begin
         mem[wa] = wd;
      end else if (wr_act && wa != byte_address && $time != wr_t0) begin
         viol_count++;
      end
      if (!wr_act && !chip_sel_n && !write_n && !nv_busy) begin
         wr_t0 = $time;
      end
      wr_act = !chip_sel_n && !write_n && !nv_busy;
      if (wr_act) begin
         wa = byte_address;
         wd = dq_in;
      end
   end
endmodule : nvsr_dev_model

//--- dv/nvsr_host_bench.sv
// Self-checking testbench for the host controller of the nonvolatile byte memory.
`timescale 1ns/1ns
module nvsr_host_bench
   import nvsr_pkg::*;
;
   localparam int LIM = 400;
   logic core_clk, resetn, cmd_valid, cmd_ready, rsp_valid;
   nvsr_cmd_type cmd_op;
   logic [ADDR_W-1:0] cmd_addr, byte_address;
   logic [DATA_W-1:0] cmd_wdata, rsp_rdata, data_lines_i, data_lines_o, dev_dq, rd;
   logic chip_sel_n, write_n, out_en_n, data_lines_oe_n, host_busy_o, host_busy_oe_n;
   logic busy_line, dev_dq_oe_n, dev_busy_n;
   logic [ADDR_W-1:0] cs_addr_q [$];
   logic cs_we_q [$];
   int failures, cmp_count, busy_cycles;
   nvsr_host #(.SAVE_WAIT(20), .RESTORE_WAIT(20), .POWERUP_WAIT(20)) u_nvsr_host (
      .core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .byte_address(byte_address), .chip_sel_n(chip_sel_n),
      .write_n(write_n), .out_en_n(out_en_n), .data_lines_i(data_lines_i),
      .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n),
      .hw_save_busy_n_i(busy_line), .hw_save_busy_n_o(host_busy_o),
      .hw_save_busy_n_oe_n(host_busy_oe_n));
   nvsr_dev_model u_nvsr_dev_model (
      .core_clk(core_clk), .byte_address(byte_address), .chip_sel_n(chip_sel_n),
      .write_n(write_n), .out_en_n(out_en_n), .dq_in(data_lines_i), .dq_dev(dev_dq),
      .dq_dev_oe_n(dev_dq_oe_n), .busy_n(dev_busy_n));
   assign data_lines_i = (data_lines_oe_n === 1'b0) ? data_lines_o : dev_dq;
   assign busy_line = dev_busy_n & (host_busy_oe_n | host_busy_o);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic step_wait(inout int n);
      @(posedge core_clk);
      #1;
      n++;
      if (n > LIM) begin
         check("wait bound", 0, 1);
         give_verdict();
      end
   endtask : step_wait
   task automatic run_cmd(input nvsr_cmd_type op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) step_wait(n);
      @(posedge core_clk);
      #1;
      cmd_valid = 1'b0;
      if (op == NVSR_CMD_READ) begin
         while (rsp_valid !== 1'b1) step_wait(n);
         rd = rsp_rdata;
      end
      while (cmd_ready !== 1'b1) step_wait(n);
   endtask : run_cmd
   task automatic check_seq(input logic [13:0] last);
      logic [13:0] e [6];
      e = '{SEQ_ADDR0, SEQ_ADDR1, SEQ_ADDR2, SEQ_ADDR3, SEQ_ADDR4, last};
      check("strobe count", 6, cs_addr_q.size());
      for (int i = 0; i < 6 && i < cs_addr_q.size(); i++) begin
         check("step address", {1'b0, e[i]}, cs_addr_q[i]);
         check("step write", 1, cs_we_q[i]);
      end
      cs_addr_q.delete();
      cs_we_q.delete();
   endtask : check_seq
   always @(negedge chip_sel_n) begin
      #1;
      cs_addr_q.push_back(byte_address);
      cs_we_q.push_back(write_n);
   end
   always @(posedge core_clk) begin
      if (busy_line === 1'b0) begin
         busy_cycles++;
         check("ready while busy", 0, cmd_ready);
      end
      if (data_lines_oe_n === 1'b0 && dev_dq_oe_n === 1'b0) begin
         check("bus contention", 1, 0);
      end
   end
   task automatic t_powerup();
      logic [ADDR_W-1:0] a [3] = '{15'h0000, 15'h1234, 15'h7fff};
      for (int i = 0; i < 3; i++) begin
         run_cmd(NVSR_CMD_READ, a[i], 8'h00);
         check("power-up data", a[i][7:0] ^ 8'h3c, rd);
      end
   endtask : t_powerup
   task automatic t_write_read();
      logic [ADDR_W-1:0] a [3] = '{15'h0001, 15'h4001, 15'h7ffe};
      logic [DATA_W-1:0] d [3] = '{8'h11, 8'h22, 8'h33};
      for (int i = 0; i < 3; i++) begin
         run_cmd(NVSR_CMD_WRITE, a[i], d[i]);
      end
      for (int i = 0; i < 3; i++) begin
         run_cmd(NVSR_CMD_READ, a[i], 8'h00);
         check("read back", d[i], rd);
      end
   endtask : t_write_read
   task automatic t_save();
      int n0, b0;
      run_cmd(NVSR_CMD_WRITE, 15'h0123, 8'ha5);
      cs_addr_q.delete();
      cs_we_q.delete();
      for (int k = 0; k < 2; k++) begin
         n0 = u_nvsr_dev_model.save_count;
         b0 = busy_cycles;
         run_cmd(NVSR_CMD_SAVE, 15'h0000, 8'h00);
         check_seq(SEQ_SAVE);
         check("save count", n0 + 1, u_nvsr_dev_model.save_count);
         check("busy seen", 1, busy_cycles > b0);
         check("shadow byte", 8'ha5, u_nvsr_dev_model.shadow[15'h0123]);
      end
   endtask : t_save
   task automatic t_restore();
      run_cmd(NVSR_CMD_WRITE, 15'h0123, 8'h5a);
      for (int k = 0; k < 2; k++) begin
         cs_addr_q.delete();
         cs_we_q.delete();
         run_cmd(NVSR_CMD_RESTORE, 15'h0000, 8'h00);
         check_seq(SEQ_RESTORE);
         run_cmd(NVSR_CMD_READ, 15'h0123, 8'h00);
         check("restored byte", 8'ha5, rd);
         check("shadow kept", 8'ha5, u_nvsr_dev_model.shadow[15'h0123]);
      end
   endtask : t_restore
   initial begin
      failures = 0;
      cmp_count = 0;
      busy_cycles = 0;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = NVSR_CMD_READ;
      cmd_addr = '0;
      cmd_wdata = '0;
      repeat (20) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      t_powerup();
      t_write_read();
      t_save();
      t_restore();
      check("device violations", 0, u_nvsr_dev_model.viol_count);
      give_verdict();
   end
endmodule : nvsr_host_bench

//--- shared/nvsr_pkg.sv
// Package with constants and types for the host-side nonvolatile memory controller.
package nvsr_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int SAVE_DURATION_MS = 10;
   localparam int RESTORE_DURATION_US = 20;
   localparam int POWERUP_RESTORE_DURATION_US = 550;
   localparam int SAVE_CYCLES = SAVE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RESTORE_CYCLES = RESTORE_DURATION_US * 1000 / CLK_PERIOD_NS;
   localparam int POWERUP_CYCLES = POWERUP_RESTORE_DURATION_US * 1000 / CLK_PERIOD_NS;
   localparam int STROBE_LOW_CYCLES = 1;
   localparam int STROBE_HIGH_CYCLES = 1;
   localparam int CNT_W = 20;
   // ----------------------------------------------------------------
   // Bus widths and command addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int SEQ_LEN = 6;
   localparam logic [13:0] SEQ_ADDR0 = 14'h0e38;
   localparam logic [13:0] SEQ_ADDR1 = 14'h31c7;
   localparam logic [13:0] SEQ_ADDR2 = 14'h03e0;
   localparam logic [13:0] SEQ_ADDR3 = 14'h3c1f;
   localparam logic [13:0] SEQ_ADDR4 = 14'h303f;
   localparam logic [13:0] SEQ_SAVE = 14'h0fc0;
   localparam logic [13:0] SEQ_RESTORE = 14'h0c63;
   // ----------------------------------------------------------------
   // Host commands
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      NVSR_CMD_READ = 2'h0,
      NVSR_CMD_WRITE = 2'h1,
      NVSR_CMD_SAVE = 2'h2,
      NVSR_CMD_RESTORE = 2'h3
   } nvsr_cmd_type;

   // Returns the command address for a step of the sequence.
   function automatic logic [13:0] nvsr_seq_addr(input logic [2:0] step, input logic save);
      logic [13:0] a;
      a = SEQ_ADDR0;
      if (step == 3'h1) begin
         a = SEQ_ADDR1;
      end else if (step == 3'h2) begin
         a = SEQ_ADDR2;
      end else if (step == 3'h3) begin
         a = SEQ_ADDR3;
      end else if (step == 3'h4) begin
         a = SEQ_ADDR4;
      end else if (step == 3'h5) begin
         a = save ? SEQ_SAVE : SEQ_RESTORE;
      end
      return a;
   endfunction : nvsr_seq_addr
endpackage : nvsr_pkg

//--- shared/nvsr_tmr_if.sv
// Interface between the sequencer and its wait timer.
`timescale 1ns/1ns
interface nvsr_tmr_if;
   logic start;
   logic [19:0] load;
   logic done;
   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface : nvsr_tmr_if

//--- verilog/nvsr_host.sv
// Host controller that drives the nonvolatile memory pins.
`timescale 1ns/1ns
module nvsr_host
   import nvsr_pkg::*;
#(
   parameter int SAVE_WAIT = SAVE_CYCLES,
   parameter int RESTORE_WAIT = RESTORE_CYCLES,
   parameter int POWERUP_WAIT = POWERUP_CYCLES
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire nvsr_cmd_type cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_wdata,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic [ADDR_W-1:0] byte_address,
   output logic chip_sel_n,
   output logic write_n,
   output logic out_en_n,
   input wire logic [DATA_W-1:0] data_lines_i,
   output logic [DATA_W-1:0] data_lines_o,
   output logic data_lines_oe_n,
   input wire logic hw_save_busy_n_i,
   output logic hw_save_busy_n_o,
   output logic hw_save_busy_n_oe_n
);
   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_POWERUP = 7'h01,
      ST_IDLE = 7'h02,
      ST_LOW = 7'h04,
      ST_HIGH = 7'h08,
      ST_SEQ_LOW = 7'h10,
      ST_SEQ_HIGH = 7'h20,
      ST_NV_WAIT = 7'h40
   } nvsr_state_type;

   nvsr_state_type state_r;
   nvsr_cmd_type op_r;
   logic [2:0] step_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic nv_busy;
   logic pu_started_r;
   localparam logic [2:0] LAST_STEP = 3'(SEQ_LEN - 2);
   nvsr_tmr_if tif ();

   nvsr_timer u_timer (
      .core_clk(core_clk),
      .resetn(resetn),
      .t(tif.tmr)
   );

   assign nv_busy = (state_r == ST_NV_WAIT) || (state_r == ST_POWERUP);
   assign cmd_ready = (state_r == ST_IDLE) && hw_save_busy_n_i && !cmd_valid ? 1'b1 :
                      (state_r == ST_IDLE) && hw_save_busy_n_i;
   assign hw_save_busy_n_o = 1'b0;
   assign hw_save_busy_n_oe_n = 1'b1;

   // Timer loads on entry to each timed state.
   always_comb begin
      tif.start = 1'b0;
      tif.load = '0;
      if (state_r == ST_POWERUP && !pu_started_r) begin
         tif.start = 1'b1;
         tif.load = 20'(POWERUP_WAIT);
      end else if (state_r == ST_IDLE && cmd_valid && hw_save_busy_n_i) begin
         tif.start = 1'b1;
         tif.load = 20'(STROBE_LOW_CYCLES);
      end else if (state_r == ST_LOW && tif.done) begin
         tif.start = 1'b1;
         tif.load = 20'(STROBE_HIGH_CYCLES);
      end else if (state_r == ST_HIGH && tif.done && op_r != NVSR_CMD_READ
                   && op_r != NVSR_CMD_WRITE) begin
         tif.start = 1'b1;
         tif.load = 20'(STROBE_LOW_CYCLES);
      end else if (state_r == ST_SEQ_LOW && tif.done) begin
         tif.start = 1'b1;
         tif.load = 20'(STROBE_HIGH_CYCLES);
      end else if (state_r == ST_SEQ_HIGH && tif.done) begin
         tif.start = 1'b1;
         if (step_r == LAST_STEP) begin
            tif.load = (op_r == NVSR_CMD_SAVE) ? 20'(SAVE_WAIT) : 20'(RESTORE_WAIT);
         end else begin
            tif.load = 20'(STROBE_LOW_CYCLES);
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_r <= ST_POWERUP;
         step_r <= 3'h0;
      end else begin
         case (state_r)
            ST_POWERUP: begin
               if (pu_started_r && tif.done && hw_save_busy_n_i) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               step_r <= 3'h0;
               if (cmd_valid && hw_save_busy_n_i) begin
                  state_r <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tif.done) begin
                  state_r <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tif.done) begin
                  if (op_r == NVSR_CMD_READ || op_r == NVSR_CMD_WRITE) begin
                     state_r <= ST_IDLE;
                  end else begin
                     state_r <= ST_SEQ_LOW;
                  end
               end
            end
            ST_SEQ_LOW: begin
               if (tif.done) begin
                  state_r <= ST_SEQ_HIGH;
               end
            end
            ST_SEQ_HIGH: begin
               if (tif.done) begin
                  if (step_r == LAST_STEP) begin
                     state_r <= ST_NV_WAIT;
                  end else begin
                     step_r <= step_r + 3'h1;
                     state_r <= ST_SEQ_LOW;
                  end
               end
            end
            ST_NV_WAIT: begin
               if (tif.done && hw_save_busy_n_i) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Power-up wait is started by a one-shot at reset release.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pu_started_r <= 1'b0;
      end else begin
         pu_started_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Command capture
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         op_r <= NVSR_CMD_READ;
         addr_r <= '0;
         wdata_r <= '0;
      end else if (state_r == ST_IDLE && cmd_valid && hw_save_busy_n_i) begin
         op_r <= cmd_op;
         addr_r <= cmd_addr;
         wdata_r <= cmd_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         byte_address <= '0;
         chip_sel_n <= 1'b1;
         write_n <= 1'b1;
         out_en_n <= 1'b1;
         data_lines_o <= '0;
         data_lines_oe_n <= 1'b1;
      end else begin
         chip_sel_n <= 1'b1;
         write_n <= 1'b1;
         out_en_n <= 1'b1;
         data_lines_oe_n <= 1'b1;
         if (state_r == ST_IDLE && cmd_valid && hw_save_busy_n_i) begin
            chip_sel_n <= 1'b0;
            if (cmd_op == NVSR_CMD_WRITE) begin
               byte_address <= cmd_addr;
               write_n <= 1'b0;
               data_lines_o <= cmd_wdata;
               data_lines_oe_n <= 1'b0;
            end else if (cmd_op == NVSR_CMD_READ) begin
               byte_address <= cmd_addr;
               out_en_n <= 1'b0;
            end else begin
               byte_address <= {1'b0, SEQ_ADDR0};
            end
         end else if (state_r == ST_LOW && !tif.done) begin
            chip_sel_n <= 1'b0;
            write_n <= (op_r == NVSR_CMD_WRITE) ? 1'b0 : 1'b1;
            out_en_n <= (op_r == NVSR_CMD_READ) ? 1'b0 : 1'b1;
            data_lines_oe_n <= (op_r == NVSR_CMD_WRITE) ? 1'b0 : 1'b1;
         end else if ((state_r == ST_HIGH || state_r == ST_SEQ_HIGH) && tif.done
                      && state_r != ST_NV_WAIT) begin
            if (state_r == ST_HIGH && op_r != NVSR_CMD_READ && op_r != NVSR_CMD_WRITE) begin
               byte_address <= {1'b0, nvsr_seq_addr(3'h1, op_r == NVSR_CMD_SAVE)};
               chip_sel_n <= 1'b0;
            end else if (state_r == ST_SEQ_HIGH && step_r != LAST_STEP) begin
               byte_address <= {1'b0, nvsr_seq_addr(step_r + 3'h2,
                                op_r == NVSR_CMD_SAVE)};
               chip_sel_n <= 1'b0;
            end
         end else if (state_r == ST_SEQ_LOW && !tif.done) begin
            chip_sel_n <= 1'b0;
         end
      end
   end

   // Read data returns when the read strobe ends.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state_r == ST_LOW && tif.done && op_r == NVSR_CMD_READ) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= data_lines_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_seq_write_high: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == ST_SEQ_LOW || state_r == ST_SEQ_HIGH) |-> write_n)
      else $error("write strobe low in sequence");
   a_write_oe_high: assert property (@(posedge core_clk) disable iff (!resetn)
      !write_n |-> out_en_n && !chip_sel_n)
      else $error("output enable low during write");
   a_busy_no_access: assert property (@(posedge core_clk) disable iff (!resetn)
      nv_busy |-> chip_sel_n && !cmd_ready)
      else $error("access during nonvolatile cycle");
   a_addr_low_bits: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == ST_SEQ_LOW) |-> byte_address[14] == 1'b0)
      else $error("sequence address top bit set");
   a_addr_stable_wr: assert property (@(posedge core_clk) disable iff (!resetn)
      (!write_n && $past(!write_n)) |-> $stable(byte_address))
      else $error("address moved during write");
   a_seq_enters_wait: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == ST_SEQ_HIGH && tif.done && step_r == LAST_STEP) |=> state_r == ST_NV_WAIT)
      else $error("nonvolatile wait not entered");
   a_idle_step_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == ST_IDLE) |=> (step_r == 3'h0 || state_r == ST_LOW))
      else $error("step not cleared");
   a_read_rsp: assert property (@(posedge core_clk) disable iff (!resetn)
      rsp_valid |-> $past(op_r) == NVSR_CMD_READ)
      else $error("response without read");
   c_read: cover property (@(posedge core_clk) rsp_valid);
   c_write: cover property (@(posedge core_clk) !write_n);
   c_save: cover property (@(posedge core_clk) state_r == ST_NV_WAIT && op_r == NVSR_CMD_SAVE);
   c_restore: cover property (@(posedge core_clk)
      state_r == ST_NV_WAIT && op_r == NVSR_CMD_RESTORE);
endmodule : nvsr_host

//--- verilog/nvsr_timer.sv
// Down counter that measures nonvolatile cycle and strobe waits.
`timescale 1ns/1ns
module nvsr_timer
   import nvsr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   nvsr_tmr_if.tmr t
);
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (t.start) begin
         cnt_r <= t.load;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 20'h00001;
      end
   end

   assign t.done = (cnt_r == '0);
endmodule : nvsr_timer
